/* nsr_event_model.sv */
// board-side event sources and speaker timer channel for the ports block
// assumes the bench calls its tasks from the aclk domain
`timescale 1ns/1ps
`default_nettype none
module nsr_event_model #(
    parameter int HALF = 20
) (
    input wire logic aclk,
    input wire logic timer_gate,
    output logic serr_pulse,
    output logic iochk_n,
    output logic refresh_done,
    output logic timer_out
);
    int cnt = 0;
    initial begin
        serr_pulse = 1'b0;
        iochk_n = 1'b1;
        refresh_done = 1'b0;
        timer_out = 1'b0;
    end
    // the counter only advances while gated, so its output freezes
    always @(posedge aclk) begin
        if (timer_gate) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) timer_out <= ~timer_out;
        end
    end
    task automatic pulse_serr();
        @(posedge aclk);
        serr_pulse <= 1'b1;
        @(posedge aclk);
        serr_pulse <= 1'b0;
    endtask
    task automatic drive_iochk(input logic lvl_n);
        @(posedge aclk);
        iochk_n <= lvl_n;
    endtask
    task automatic pulse_refresh();
        @(posedge aclk);
        refresh_done <= 1'b1;
        @(posedge aclk);
        refresh_done <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* nsr_pkg.sv */
// package for the legacy system control ports block
// assumes a 100 MHz aclk and an AXI4-Lite register bus
package nsr_pkg;
    // printed port offsets are not all multiples of four: keep as indices
    localparam logic [7:0] IDX_NMI_STATUS_CTRL = 8'h61;
    localparam logic [7:0] IDX_NMI_MASK_INDEX = 8'h70;
    localparam logic [7:0] IDX_FAST_RESET_A20 = 8'h92;
    localparam logic [7:0] IDX_CHIPSEL_B_CFG = 8'hA0;
    // register bus byte address width
    localparam int ADDR_W = 12;
    localparam logic [7:0] STATUS_CTRL_RESET = 8'h00;
    localparam logic [7:0] MASK_INDEX_RESET = 8'h80;
    localparam logic [7:0] FAST_RESET_RESET = 8'h24;
    localparam logic [7:0] CHIPSEL_B_RESET = 8'h00;
    localparam int BIT_SERR_STAT = 7;
    localparam int BIT_IOCHK_STAT = 6;
    localparam int BIT_TMR_OUT = 5;
    localparam int BIT_REFRESH_TGL = 4;
    localparam int BIT_IOCHK_DIS = 3;
    localparam int BIT_SERR_DIS = 2;
    localparam int BIT_SPK_DATA = 1;
    localparam int BIT_TMR_GATE = 0;
    localparam int BIT_NMI_MASK = 7;
    localparam int BIT_A20 = 1;
    localparam int BIT_FAST_RST = 0;
    localparam int BIT_P92_EN = 6;
    localparam logic [7:0] FAST_RESET_FIXED = 8'h24;
    // alternate reset pulse: four bus clocks of a 33 MHz bus
    localparam int SYSCLK_PERIOD_NS = 30;
    localparam int ALTERNATE_CPU_RESET_N_SYSCLKS = 4;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ALTERNATE_CPU_RESET_N_CYCLES =
        (ALTERNATE_CPU_RESET_N_SYSCLKS * SYSCLK_PERIOD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // forwarded expansion-bus copy of a mask/index port access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] index;
        logic mask;
    } nsr_fwd_s;
endpackage

/* nsr_pulse.sv */
// one-shot low pulse generator for the alternate cpu reset
// assumes trig is a one-cycle pulse in the aclk domain
`timescale 1ns/1ps
`default_nettype none
module nsr_pulse #(
    parameter int CYCLES = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic trig,
    output logic pulse_n
);
    logic [7:0] cnt_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 8'h00;
            pulse_n <= 1'b1;
        end else if (trig) begin
            cnt_r <= 8'(CYCLES - 1);
            pulse_n <= 1'b0;
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end else begin
            pulse_n <= 1'b1;
        end
    end

    // counts the low cycles so the length check needs no long repetition
    logic [7:0] low_cnt_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_cnt_r <= 8'h00;
        end else if (!pulse_n) begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end else begin
            low_cnt_r <= 8'h00;
        end
    end

    // a reset in mid-pulse cuts it short, so the edge after reset is skipped
    a_pulse_len: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(pulse_n) && $past(aresetn) |-> low_cnt_r == 8'(CYCLES))
        else $error("alternate reset pulse length wrong");
    a_pulse_bound: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !pulse_n |-> low_cnt_r < 8'(CYCLES))
        else $error("alternate reset pulse too long");
endmodule
`default_nettype wire

/* nsr_top.sv */
// nmi status/speaker, nmi mask/clock index and fast-reset/a20 ports
// assumes an AXI4-Lite master, synchronous event inputs and one aclk
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module nsr_top #(
    parameter int RST_CYCLES = nsr_pkg::ALTERNATE_CPU_RESET_N_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serr_pulse,
    input wire logic iochk_n,
    input wire logic refresh_done,
    input wire logic timer_out,
    output logic timer_gate,
    output logic speaker_tone_out,
    output logic nmi_req,
    output logic alternate_addr_line20_gate,
    output logic alternate_cpu_reset_n,
    output nsr_pkg::nsr_fwd_s fwd_r
);
    logic [7:0] ctrl_r;
    logic serr_stat_r;
    logic iochk_stat_r;
    logic refresh_tgl_r;
    logic [7:0] mask_index_r;
    logic a20_r;
    logic fast_rst_r;
    logic [7:0] csel_b_r;
    logic [11:0] awaddr_r;
    logic aw_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_held_r;
    logic wr_fire;
    logic [9:0] wr_idx;
    logic wr_ok;
    logic [7:0] wbyte;
    logic rst_trig;
    logic rst_pulse_n;

    function automatic logic [9:0] word_idx(input logic [11:0] a);
        return a[11:2];
    endfunction

    function automatic logic hit(input logic [9:0] idx,
                                 input logic [7:0] reg_idx);
        return idx == {2'b00, reg_idx};
    endfunction

    // write channel: address and data may arrive in either order
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_idx = word_idx(awaddr_r);
    assign wbyte = wdata_r[7:0];
    assign wr_ok = wr_fire && wstrb_r[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r <= 12'h000;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_r && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= nsr_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (hit(wr_idx, nsr_pkg::IDX_NMI_STATUS_CTRL) ||
                hit(wr_idx, nsr_pkg::IDX_NMI_MASK_INDEX) ||
                hit(wr_idx, nsr_pkg::IDX_CHIPSEL_B_CFG) ||
                (hit(wr_idx, nsr_pkg::IDX_FAST_RESET_A20) &&
                 csel_b_r[nsr_pkg::BIT_P92_EN])) begin
                s_axi_bresp <= nsr_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= nsr_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control bits 3:0; upper bits written are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= nsr_pkg::STATUS_CTRL_RESET;
        end else if (wr_ok && hit(wr_idx, nsr_pkg::IDX_NMI_STATUS_CTRL)) begin
            ctrl_r <= {4'h0, wbyte[3:0]};
        end
    end

    // status latches: a disable of one clears and blocks; a set arriving
    // while enabled wins over nothing else, so no event is lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serr_stat_r <= 1'b0;
        end else if (ctrl_r[nsr_pkg::BIT_SERR_DIS]) begin
            serr_stat_r <= 1'b0;
        end else if (serr_pulse) begin
            serr_stat_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            iochk_stat_r <= 1'b0;
        end else if (ctrl_r[nsr_pkg::BIT_IOCHK_DIS]) begin
            iochk_stat_r <= 1'b0;
        end else if (!iochk_n) begin
            iochk_stat_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            refresh_tgl_r <= 1'b0;
        end else if (refresh_done) begin
            refresh_tgl_r <= !refresh_tgl_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_index_r <= nsr_pkg::MASK_INDEX_RESET;
        end else if (wr_ok && hit(wr_idx, nsr_pkg::IDX_NMI_MASK_INDEX)) begin
            mask_index_r <= wbyte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            csel_b_r <= nsr_pkg::CHIPSEL_B_RESET;
        end else if (wr_ok && hit(wr_idx, nsr_pkg::IDX_CHIPSEL_B_CFG)) begin
            csel_b_r <= wbyte;
        end
    end

    // reset pulse fires only on a zero-to-one change of the stored bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a20_r <= nsr_pkg::FAST_RESET_RESET[nsr_pkg::BIT_A20];
            fast_rst_r <= 1'b0;
            rst_trig <= 1'b0;
        end else if (wr_ok && hit(wr_idx, nsr_pkg::IDX_FAST_RESET_A20) &&
                     csel_b_r[nsr_pkg::BIT_P92_EN]) begin
            a20_r <= wbyte[nsr_pkg::BIT_A20];
            fast_rst_r <= wbyte[nsr_pkg::BIT_FAST_RST];
            rst_trig <= wbyte[nsr_pkg::BIT_FAST_RST] && !fast_rst_r;
        end else begin
            rst_trig <= 1'b0;
        end
    end

    nsr_pulse #(
        .CYCLES(RST_CYCLES)
    ) u_pulse (
        .aclk(aclk),
        .aresetn(aresetn),
        .trig(rst_trig),
        .pulse_n(rst_pulse_n)
    );

    // forwarded copy of mask/index accesses for the clock component
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fwd_r <= '0;
        end else begin
            fwd_r.wr <= wr_ok && hit(wr_idx, nsr_pkg::IDX_NMI_MASK_INDEX);
            fwd_r.rd <= s_axi_arvalid && s_axi_arready &&
                hit(word_idx(s_axi_araddr), nsr_pkg::IDX_NMI_MASK_INDEX);
            fwd_r.index <= wbyte[6:0];
            fwd_r.mask <= wbyte[nsr_pkg::BIT_NMI_MASK];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_gate <= 1'b0;
            speaker_tone_out <= 1'b0;
            nmi_req <= 1'b0;
            alternate_addr_line20_gate <= 1'b0;
            alternate_cpu_reset_n <= 1'b1;
        end else begin
            timer_gate <= ctrl_r[nsr_pkg::BIT_TMR_GATE];
            speaker_tone_out <= ctrl_r[nsr_pkg::BIT_SPK_DATA] &&
                timer_out;
            nmi_req <= (serr_stat_r || iochk_stat_r) &&
                !mask_index_r[nsr_pkg::BIT_NMI_MASK];
            alternate_addr_line20_gate <= a20_r;
            alternate_cpu_reset_n <= rst_pulse_n;
        end
    end

    // read channel; mask/index is write-only and reads as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= nsr_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= nsr_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            if (hit(word_idx(s_axi_araddr), nsr_pkg::IDX_NMI_STATUS_CTRL)) begin
                s_axi_rdata[7:0] <= {serr_stat_r, iochk_stat_r, timer_out,
                    refresh_tgl_r, ctrl_r[3:0]};
            end else if (hit(word_idx(s_axi_araddr),
                             nsr_pkg::IDX_CHIPSEL_B_CFG)) begin
                s_axi_rdata[7:0] <= csel_b_r;
            end else if (hit(word_idx(s_axi_araddr),
                             nsr_pkg::IDX_FAST_RESET_A20) &&
                         csel_b_r[nsr_pkg::BIT_P92_EN]) begin
                s_axi_rdata[7:0] <= nsr_pkg::FAST_RESET_FIXED |
                    {6'h00, a20_r, fast_rst_r};
            end else if (!hit(word_idx(s_axi_araddr),
                              nsr_pkg::IDX_NMI_MASK_INDEX)) begin
                s_axi_rresp <= nsr_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid;
        end
    end

    a_nmi_gate: assert property (
        @(posedge aclk) disable iff (!aresetn)
        mask_index_r[nsr_pkg::BIT_NMI_MASK] |=> !nmi_req)
        else $error("nmi raised while masked");
    a_serr_latch: assert property (
        @(posedge aclk) disable iff (!aresetn)
        serr_pulse && !ctrl_r[nsr_pkg::BIT_SERR_DIS] |=> serr_stat_r)
        else $error("system error not latched");
    a_iochk_latch: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !iochk_n && !ctrl_r[nsr_pkg::BIT_IOCHK_DIS] |=> iochk_stat_r)
        else $error("channel check not latched");
    a_serr_clear: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ctrl_r[nsr_pkg::BIT_SERR_DIS] |=> !serr_stat_r)
        else $error("system error not cleared");
    a_iochk_clear: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ctrl_r[nsr_pkg::BIT_IOCHK_DIS] |=> !iochk_stat_r)
        else $error("channel check not cleared");
    a_nmi_raise: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (serr_stat_r || iochk_stat_r) &&
        !mask_index_r[nsr_pkg::BIT_NMI_MASK] |=> nmi_req)
        else $error("nmi not raised");
    a_speaker_low: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !ctrl_r[nsr_pkg::BIT_SPK_DATA] |=> !speaker_tone_out)
        else $error("speaker not held low");
    a_speaker_follow: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ctrl_r[nsr_pkg::BIT_SPK_DATA] |=>
        speaker_tone_out == $past(timer_out))
        else $error("speaker does not follow timer");
    a_gate_follow: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ##1 timer_gate == $past(ctrl_r[nsr_pkg::BIT_TMR_GATE]))
        else $error("timer gate mismatch");
    a_refresh_tgl: assert property (
        @(posedge aclk) disable iff (!aresetn)
        refresh_done |=> refresh_tgl_r != $past(refresh_tgl_r))
        else $error("refresh toggle did not invert");
    a_a20_follow: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ##1 alternate_addr_line20_gate == $past(a20_r))
        else $error("a20 gate mismatch");
    a_no_repulse: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rst_trig |-> !$past(fast_rst_r))
        else $error("reset pulse without zero write");
    a_fwd_mask: assert property (
        @(posedge aclk) disable iff (!aresetn)
        fwd_r.wr |-> {fwd_r.mask, fwd_r.index} == mask_index_r)
        else $error("forwarded mask and index differ from stored");

    c_serr_nmi: cover property (@(posedge aclk) disable iff (!aresetn)
        serr_pulse ##2 nmi_req);
    c_fast_reset: cover property (@(posedge aclk) disable iff (!aresetn)
        $fell(alternate_cpu_reset_n));
    c_mask_write: cover property (@(posedge aclk) disable iff (!aresetn)
        fwd_r.wr);
    c_iochk_nmi: cover property (@(posedge aclk) disable iff (!aresetn)
        !iochk_n ##2 nmi_req);
endmodule
`default_nettype wire

/* tb_nmi_speaker_fast_reset_ports.sv */
// self-checking bench for the legacy nmi, speaker and fast-reset ports
// assumes nsr_pkg, nsr_top and nsr_event_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_nmi_speaker_fast_reset_ports;
    localparam logic [11:0] A_SC = {2'b00, nsr_pkg::IDX_NMI_STATUS_CTRL, 2'b00};
    localparam logic [11:0] A_MI = {2'b00, nsr_pkg::IDX_NMI_MASK_INDEX, 2'b00};
    localparam logic [11:0] A_P92 = {2'b00, nsr_pkg::IDX_FAST_RESET_A20, 2'b00};
    localparam logic [11:0] A_CSB = {2'b00, nsr_pkg::IDX_CHIPSEL_B_CFG, 2'b00};
    localparam logic [11:0] A_BAD = 12'h004;
    localparam logic [1:0] OK = nsr_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = nsr_pkg::RESP_SLVERR;
    localparam int PW = nsr_pkg::ALTERNATE_CPU_RESET_N_CYCLES;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic serr_pulse, iochk_n, refresh_done, timer_out, timer_gate;
    logic spk, nmi_req, a20, rst_n;
    nsr_pkg::nsr_fwd_s fwd;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int fwd_wr_n = 0;
    int fwd_rd_n = 0;
    logic [7:0] fwd_last = 8'h00;

    always #5 aclk = ~aclk;

    nsr_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .serr_pulse(serr_pulse), .iochk_n(iochk_n),
        .refresh_done(refresh_done), .timer_out(timer_out),
        .timer_gate(timer_gate), .speaker_tone_out(spk), .nmi_req(nmi_req),
        .alternate_addr_line20_gate(a20), .alternate_cpu_reset_n(rst_n),
        .fwd_r(fwd));
    nsr_event_model ev (.aclk(aclk), .timer_gate(timer_gate),
        .serr_pulse(serr_pulse), .iochk_n(iochk_n),
        .refresh_done(refresh_done), .timer_out(timer_out));

    always @(posedge aclk) begin
        if (fwd.wr === 1'b1) fwd_wr_n++;
        if (fwd.wr === 1'b1) fwd_last = {fwd.mask, fwd.index};
        if (fwd.rd === 1'b1) fwd_rd_n++;
        cycles++;
        // well above the few hundred cycles the scenarios need
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic clks(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // write address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [11:0] a, input logic [7:0] d,
                          input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic axi_rd(input logic [11:0] a, input logic [1:0] er,
                          input logic [7:0] ed);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        if (er == OK) chk("rdata", {24'h0, ed}, rdata);
    endtask
    task automatic pulse_width(output int w);
        int n;
        n = 0;
        w = 0;
        while (rst_n === 1'b1 && n < 20) begin
            @(posedge aclk);
            n++;
        end
        while (rst_n === 1'b0 && w < 40) begin
            @(posedge aclk);
            w++;
        end
    endtask

    task automatic t_nmi();
        int n;
        n = fwd_wr_n;
        axi_wr(A_MI, 8'h15, OK);
        clks(2);
        chk("fwd writes", n + 1, fwd_wr_n);
        chk("fwd data", 8'h15, fwd_last);
        n = fwd_rd_n;
        axi_rd(A_MI, OK, 8'h00);
        clks(2);
        chk("fwd reads", n + 1, fwd_rd_n);
        ev.pulse_serr();
        clks(3);
        chk("nmi serr", 1, nmi_req);
        axi_rd(A_SC, OK, 8'h80);
        axi_wr(A_MI, 8'h95, OK);
        clks(3);
        chk("nmi masked", 0, nmi_req);
        chk("fwd mask", 8'h95, fwd_last);
        axi_wr(A_MI, 8'h15, OK);
        clks(3);
        chk("nmi unmasked", 1, nmi_req);
        axi_wr(A_SC, 8'h04, OK);
        axi_rd(A_SC, OK, 8'h04);
        ev.pulse_serr();
        clks(3);
        axi_rd(A_SC, OK, 8'h04);
        chk("nmi serr blocked", 0, nmi_req);
        axi_wr(A_SC, 8'h00, OK);
        ev.drive_iochk(1'b0);
        clks(3);
        axi_rd(A_SC, OK, 8'h40);
        chk("nmi iochk", 1, nmi_req);
        axi_wr(A_SC, 8'h08, OK);
        axi_rd(A_SC, OK, 8'h08);
        chk("nmi iochk blocked", 0, nmi_req);
        ev.drive_iochk(1'b1);
        axi_wr(A_SC, 8'h00, OK);
        axi_rd(A_SC, OK, 8'h00);
    endtask
    task automatic t_refresh();
        repeat (3) ev.pulse_refresh();
        clks(2);
        axi_rd(A_SC, OK, 8'h10);
        ev.pulse_refresh();
        clks(2);
        axi_rd(A_SC, OK, 8'h00);
    endtask
    task automatic t_speaker();
        int n;
        axi_wr(A_SC, 8'h03, OK);
        clks(3);
        chk("gate on", 1, timer_gate);
        n = 0;
        while (timer_out !== 1'b1 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        clks(2);
        chk("speaker follows", 1, spk);
        axi_wr(A_SC, 8'h02, OK);
        clks(3);
        chk("gate off", 0, timer_gate);
        clks(60);
        chk("timer frozen", 1, timer_out);
        axi_rd(A_SC, OK, 8'h22);
        chk("speaker high", 1, spk);
        axi_wr(A_SC, 8'h00, OK);
        clks(3);
        chk("speaker low", 0, spk);
        axi_rd(A_SC, OK, 8'h20);
    endtask
    task automatic t_port92();
        int w;
        axi_rd(A_BAD, ERR, 8'h00);
        axi_rd(A_P92, ERR, 8'h00);
        axi_wr(A_P92, 8'h02, ERR);
        clks(3);
        chk("a20 refused", 0, a20);
        axi_wr(A_CSB, 8'h40, OK);
        axi_rd(A_CSB, OK, 8'h40);
        axi_rd(A_P92, OK, nsr_pkg::FAST_RESET_RESET);
        axi_wr(A_P92, 8'h02, OK);
        clks(3);
        chk("a20 high", 1, a20);
        axi_rd(A_P92, OK, 8'h26);
        axi_wr(A_P92, 8'h03, OK);
        pulse_width(w);
        chk("reset pulse", PW, w);
        axi_rd(A_P92, OK, 8'h27);
        axi_wr(A_P92, 8'h03, OK);
        pulse_width(w);
        chk("no second pulse", 0, w);
        axi_wr(A_P92, 8'h02, OK);
        axi_wr(A_P92, 8'h03, OK);
        pulse_width(w);
        chk("pulse rearmed", PW, w);
        // reset in mid-run must drop the stored fast-reset bit and a20
        @(posedge aclk);
        aresetn <= 1'b0;
        clks(2);
        aresetn <= 1'b1;
        clks(2);
        chk("a20 after reset", 0, a20);
        chk("nmi after reset", 0, nmi_req);
        axi_wr(A_CSB, 8'h40, OK);
        axi_rd(A_P92, OK, nsr_pkg::FAST_RESET_RESET);
    endtask

    initial begin
        clks(5);
        aresetn <= 1'b1;
        clks(2);
        chk("rst_n idle", 1, rst_n);
        chk("nmi idle", 0, nmi_req);
        axi_rd(A_SC, OK, nsr_pkg::STATUS_CTRL_RESET);
        t_nmi();
        t_refresh();
        t_speaker();
        t_port92();
        conclude();
    end
endmodule
`default_nettype wire
